// file: hw/tcc_timer.sv
// 16-bit timer/event counter with two compares, two captures and a toggle output
//
// Functional notes
// - 16-bit up-counter on selected clock tick
// - reset selects external count pin clock
// - run bit stops and zeroes counter
// - clear enable resets counter on match B
// - two comparators pulse their compare interrupts
// - compare write: word, or low then high
// - capture read: word, or low then high
// - capture mode zero disables hardware capture, default
// - mode 01: count pin rise, second pin rise
// - mode 10: count pin rise, then fall
// - mode 10 moves pin interrupt to fall
// - mode 11: flip-flop rise and fall capture
// - writing zero to trigger captures into A
// - four enabled events toggle output flip-flop
// - command field clears, sets or inverts flip-flop
// - pin driven by flip-flop only when both selects set
// - event counting on count pin rising edge
// - duty from A, period from B, A<B
// - otherwise pin interrupt on rising edge
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "tcc_params.svh"
`default_nettype none
module tcc_timer
	import tcc_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire tcc_bus_req_t reg_req_in,
	output logic [15:0] reg_rdata_out,
	input wire logic count_capture_input_in,
	input wire logic second_capture_input_in,
	input wire logic port_level_in,
	output logic pulse_output_pin_out,
	output logic pulse_output_pin_oe_out,
	output logic compare_a_interrupt_out,
	output logic compare_b_interrupt_out,
	output logic capture_input_interrupt_out
);
	localparam logic [3:0] CMP_LO [2] = '{`TCC_ADDR_CMP_A_LO, `TCC_ADDR_CMP_B_LO};
	localparam logic [3:0] CMP_HI [2] = '{`TCC_ADDR_CMP_A_HI, `TCC_ADDR_CMP_B_HI};
	localparam logic [3:0] CAP_LO [2] = '{`TCC_ADDR_CAP_A_LO, `TCC_ADDR_CAP_B_LO};
	localparam logic [3:0] CAP_HI [2] = '{`TCC_ADDR_CAP_A_HI, `TCC_ADDR_CAP_B_HI};

	function automatic logic wr_hit(input tcc_bus_req_t r, input logic [3:0] a);
		return r.wr && (r.addr == a);
	endfunction

	function automatic logic rd_hit(input tcc_bus_req_t r, input logic [3:0] a);
		return r.rd && (r.addr == a);
	endfunction

	logic [15:0] main_up_counter_ff;
	logic [15:0] nxt_main_up_counter;
	logic [15:0] compare_reg_ff [2];
	logic [7:0] pend_lo_ff [2];
	logic [15:0] capture_reg_ff [2];
	logic [7:0] cap_hi_shadow_ff [2];
	tcc_mode_t mode_ff;
	logic [3:0] tog_en_ff;
	logic counter_run_bit_ff;
	logic prescaler_run_bit_ff;
	logic pin_direction_bit_ff;
	logic pulse_output_select_ff;
	logic [`TCC_COARSE_LOG2-1:0] presc_ff;
	logic output_flipflop_ff;
	logic nxt_output_flipflop;
	logic ff_prev_ff;
	logic cnt_pin_s1_ff;
	logic cnt_pin_s2_ff;
	logic cnt_pin_prev_ff;
	logic sec_pin_s1_ff;
	logic sec_pin_s2_ff;
	logic sec_pin_prev_ff;
	logic [15:0] reg_rdata_ff;
	logic [15:0] nxt_rdata;
	logic cmp_a_irq_ff;
	logic cmp_b_irq_ff;
	logic cap_irq_ff;

	wire logic cnt_rise = cnt_pin_s2_ff && !cnt_pin_prev_ff;
	wire logic cnt_fall = !cnt_pin_s2_ff && cnt_pin_prev_ff;
	wire logic sec_rise = sec_pin_s2_ff && !sec_pin_prev_ff;
	wire logic ff_rise = output_flipflop_ff && !ff_prev_ff;
	wire logic ff_fall = !output_flipflop_ff && ff_prev_ff;
	wire logic fine_tick = prescaler_run_bit_ff && (presc_ff[`TCC_FINE_LOG2-1:0] == '1);
	wire logic coarse_tick = prescaler_run_bit_ff && (presc_ff == '1);
	wire logic tick;
	wire logic [1:0] match;
	wire logic clear_on_b;
	wire logic soft_cap;
	wire logic tog_wr = wr_hit(reg_req_in, `TCC_ADDR_TOGGLE);
	wire tcc_ffcmd_t ff_cmd = tcc_ffcmd_t'(reg_req_in.wdata[`TCC_TOG_CMD_LSB +: 2]);
	wire logic [7:0] mode_rd;
	wire logic [7:0] tog_rd;
	wire logic [7:0] run_rd;
	wire logic [7:0] status_rd;
	tcc_events_t ev;
	logic toggle;

	// pins are asynchronous: two stages, then an edge-detect stage
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt_pin_s1_ff <= 1'b0;
			cnt_pin_s2_ff <= 1'b0;
			cnt_pin_prev_ff <= 1'b0;
			sec_pin_s1_ff <= 1'b0;
			sec_pin_s2_ff <= 1'b0;
			sec_pin_prev_ff <= 1'b0;
		end else begin
			cnt_pin_s1_ff <= count_capture_input_in;
			cnt_pin_s2_ff <= cnt_pin_s1_ff;
			cnt_pin_prev_ff <= cnt_pin_s2_ff;
			sec_pin_s1_ff <= second_capture_input_in;
			sec_pin_s2_ff <= sec_pin_s1_ff;
			sec_pin_prev_ff <= sec_pin_s2_ff;
		end
	end

	// prescaler holds at zero while stopped
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			presc_ff <= '0;
		else if (!prescaler_run_bit_ff)
			presc_ff <= '0;
		else
			presc_ff <= presc_ff + 1'b1;
	end

	assign tick = (mode_ff.clk_sel == TCC_CLK_EXT) ? cnt_rise :
		(mode_ff.clk_sel == TCC_CLK_FINE) ? fine_tick :
		(mode_ff.clk_sel == TCC_CLK_COARSE) ? coarse_tick : 1'b0;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_chan
			assign match[gi] = counter_run_bit_ff && tick && (main_up_counter_ff == compare_reg_ff[gi]);

			// low byte waits until the high byte lands
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					compare_reg_ff[gi] <= `TCC_CMP_RST;
					pend_lo_ff[gi] <= 8'h00;
				end else if (wr_hit(reg_req_in, CMP_LO[gi]) && reg_req_in.word) begin
					compare_reg_ff[gi] <= reg_req_in.wdata;
				end else if (wr_hit(reg_req_in, CMP_LO[gi])) begin
					pend_lo_ff[gi] <= reg_req_in.wdata[7:0];
				end else if (wr_hit(reg_req_in, CMP_HI[gi])) begin
					compare_reg_ff[gi] <= {reg_req_in.wdata[7:0], pend_lo_ff[gi]};
				end
			end

			// low-byte read freezes the high byte for the following read
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in)
					cap_hi_shadow_ff[gi] <= 8'h00;
				else if (rd_hit(reg_req_in, CAP_LO[gi]) && !reg_req_in.word)
					cap_hi_shadow_ff[gi] <= capture_reg_ff[gi][15:8];
			end

			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in)
					capture_reg_ff[gi] <= `TCC_CAP_RST;
				else if (gi == 0 ? ev.cap_a : ev.cap_b)
					capture_reg_ff[gi] <= main_up_counter_ff;
			end
		end
	endgenerate

	assign clear_on_b = match[1] && mode_ff.clr_en;
	assign nxt_main_up_counter = !counter_run_bit_ff ? 16'h0000 :
		!tick ? main_up_counter_ff :
		clear_on_b ? 16'h0000 : 16'(main_up_counter_ff + 16'h0001);

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			main_up_counter_ff <= 16'h0000;
		else
			main_up_counter_ff <= nxt_main_up_counter;
	end

	assign soft_cap = wr_hit(reg_req_in, `TCC_ADDR_MODE) && !reg_req_in.wdata[`TCC_MODE_SOFT_BIT];

	// capture sources per mode; off means hardware never latches
	always_comb begin
		ev.match_a = match[0];
		ev.match_b = match[1];
		ev.cap_a = soft_cap;
		ev.cap_b = 1'b0;
		unique case (mode_ff.capm)
			TCC_CAPM_OFF: begin
				ev.cap_b = 1'b0;
			end
			TCC_CAPM_TWO_PIN: begin
				ev.cap_a = soft_cap || cnt_rise;
				ev.cap_b = sec_rise;
			end
			TCC_CAPM_PULSE: begin
				ev.cap_a = soft_cap || cnt_rise;
				ev.cap_b = cnt_fall;
			end
			TCC_CAPM_FLIPFLOP: begin
				ev.cap_a = soft_cap || ff_rise;
				ev.cap_b = ff_fall;
			end
		endcase
		toggle = ^(ev & tog_en_ff);
	end

	// a clear, set or invert command write overrides event toggles in the same cycle
	always_comb begin
		nxt_output_flipflop = output_flipflop_ff ^ toggle;
		if (tog_wr) begin
			unique case (ff_cmd)
				TCC_FF_CLR: nxt_output_flipflop = 1'b0;
				TCC_FF_SET: nxt_output_flipflop = 1'b1;
				TCC_FF_INV: nxt_output_flipflop = !output_flipflop_ff;
				TCC_FF_HOLD: nxt_output_flipflop = output_flipflop_ff ^ toggle;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			output_flipflop_ff <= `TCC_FF_RST;
			ff_prev_ff <= `TCC_FF_RST;
		end else begin
			output_flipflop_ff <= nxt_output_flipflop;
			ff_prev_ff <= output_flipflop_ff;
		end
	end

	// control registers
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mode_ff <= '{clr_en: 1'b0, capm: TCC_CAPM_OFF, clk_sel: TCC_CLK_EXT};
			tog_en_ff <= `TCC_TOG_EN_RST;
			counter_run_bit_ff <= 1'b0;
			prescaler_run_bit_ff <= 1'b0;
			pin_direction_bit_ff <= 1'b0;
			pulse_output_select_ff <= 1'b0;
		end else begin
			if (wr_hit(reg_req_in, `TCC_ADDR_MODE)) begin
				mode_ff.clk_sel <= tcc_clk_sel_t'(reg_req_in.wdata[`TCC_MODE_CLK_LSB +: 2]);
				mode_ff.capm <= tcc_capm_t'(reg_req_in.wdata[`TCC_MODE_CAPM_LSB +: 2]);
				mode_ff.clr_en <= reg_req_in.wdata[`TCC_MODE_CLR_BIT];
			end
			if (tog_wr)
				tog_en_ff <= reg_req_in.wdata[`TCC_TOG_EN_LSB +: 4];
			if (wr_hit(reg_req_in, `TCC_ADDR_RUN)) begin
				counter_run_bit_ff <= reg_req_in.wdata[`TCC_RUN_CNT_BIT];
				prescaler_run_bit_ff <= reg_req_in.wdata[`TCC_RUN_PRE_BIT];
			end
			if (wr_hit(reg_req_in, `TCC_ADDR_PORT_DIR))
				pin_direction_bit_ff <= reg_req_in.wdata[`TCC_PORT_BIT];
			if (wr_hit(reg_req_in, `TCC_ADDR_PORT_FUNC))
				pulse_output_select_ff <= reg_req_in.wdata[`TCC_PORT_BIT];
		end
	end

	// interrupt pulses, one cycle each
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cmp_a_irq_ff <= 1'b0;
			cmp_b_irq_ff <= 1'b0;
			cap_irq_ff <= 1'b0;
		end else begin
			cmp_a_irq_ff <= match[0];
			cmp_b_irq_ff <= match[1];
			cap_irq_ff <= (mode_ff.capm == TCC_CAPM_PULSE) ? cnt_fall : cnt_rise;
		end
	end

	// read side: trigger bit always reads one, command field reads hold
	assign mode_rd = 8'({1'b1, mode_ff}) | 8'h00;
	assign tog_rd = 8'({tog_en_ff, TCC_FF_HOLD});
	assign run_rd = 8'({prescaler_run_bit_ff, counter_run_bit_ff}) << `TCC_RUN_CNT_BIT;
	assign status_rd = 8'({sec_pin_s2_ff, cnt_pin_s2_ff, output_flipflop_ff});
	assign nxt_rdata = !reg_req_in.rd ? 16'h0000 :
		(reg_req_in.addr == CAP_LO[0]) ? (reg_req_in.word ? capture_reg_ff[0] : {8'h00, capture_reg_ff[0][7:0]}) :
		(reg_req_in.addr == CAP_HI[0]) ? {8'h00, cap_hi_shadow_ff[0]} :
		(reg_req_in.addr == CAP_LO[1]) ? (reg_req_in.word ? capture_reg_ff[1] : {8'h00, capture_reg_ff[1][7:0]}) :
		(reg_req_in.addr == CAP_HI[1]) ? {8'h00, cap_hi_shadow_ff[1]} :
		(reg_req_in.addr == `TCC_ADDR_MODE) ? {8'h00, mode_rd} :
		(reg_req_in.addr == `TCC_ADDR_TOGGLE) ? {8'h00, tog_rd} :
		(reg_req_in.addr == `TCC_ADDR_RUN) ? {8'h00, run_rd} :
		(reg_req_in.addr == `TCC_ADDR_PORT_DIR) ? {8'h00, 8'(pin_direction_bit_ff) << `TCC_PORT_BIT} :
		(reg_req_in.addr == `TCC_ADDR_PORT_FUNC) ? {8'h00, 8'(pulse_output_select_ff) << `TCC_PORT_BIT} :
		(reg_req_in.addr == `TCC_ADDR_STATUS) ? {8'h00, status_rd} : 16'h0000;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			reg_rdata_ff <= 16'h0000;
		else
			reg_rdata_ff <= nxt_rdata;
	end

	assign reg_rdata_out = reg_rdata_ff;
	assign compare_a_interrupt_out = cmp_a_irq_ff;
	assign compare_b_interrupt_out = cmp_b_irq_ff;
	assign capture_input_interrupt_out = cap_irq_ff;
	assign pulse_output_pin_out = (pin_direction_bit_ff && pulse_output_select_ff) ? output_flipflop_ff : port_level_in;
	assign pulse_output_pin_oe_out = pin_direction_bit_ff;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	a_stop_clears_count: assert property (!counter_run_bit_ff |=> main_up_counter_ff == 16'h0000)
		else $error("stopped counter not zero");
	a_count_step_wrap: assert property (counter_run_bit_ff && tick && !clear_on_b
		|=> main_up_counter_ff == 16'($past(main_up_counter_ff) + 16'h0001))
		else $error("counter did not step by one");
	a_clear_on_b: assert property (counter_run_bit_ff && tick && match[1] && mode_ff.clr_en
		|=> main_up_counter_ff == 16'h0000)
		else $error("counter not cleared on compare b");
	a_match_a_irq: assert property (counter_run_bit_ff && tick && main_up_counter_ff == compare_reg_ff[0]
		|=> compare_a_interrupt_out ##1 !compare_a_interrupt_out || match[0])
		else $error("compare a interrupt missing");
	a_capture_off_idle: assert property (mode_ff.capm == TCC_CAPM_OFF && !soft_cap
		|=> $stable(capture_reg_ff[0]) && $stable(capture_reg_ff[1]))
		else $error("capture while disabled");
	a_pulse_fall_cap: assert property (mode_ff.capm == TCC_CAPM_PULSE && cnt_fall
		|=> capture_reg_ff[1] == $past(main_up_counter_ff) && capture_input_interrupt_out)
		else $error("falling edge capture wrong");
	a_soft_cap_value: assert property (soft_cap |=> capture_reg_ff[0] == $past(main_up_counter_ff))
		else $error("software capture wrong");
	a_ff_cmd_set: assert property (tog_wr && ff_cmd == TCC_FF_SET |=> output_flipflop_ff)
		else $error("flip-flop set command ignored");
	a_pin_select: assert property (pin_direction_bit_ff && pulse_output_select_ff
		|-> pulse_output_pin_out == output_flipflop_ff)
		else $error("pin not driven by flip-flop");
	a_rise_irq: assert property (mode_ff.capm != TCC_CAPM_PULSE && cnt_rise |=> capture_input_interrupt_out)
		else $error("rising pin interrupt missing");

	c_clear_on_b: cover property (clear_on_b);
	c_soft_capture: cover property (soft_cap);
	c_match_toggle: cover property (match[0] && tog_en_ff[0] ##[1:100] match[1] && tog_en_ff[1]);
	c_pulse_capture: cover property (mode_ff.capm == TCC_CAPM_PULSE && cnt_fall);
endmodule // tcc_timer
`default_nettype wire

// file: common/tcc_params.svh
// offsets, field positions, reset values and prescaler counts of the 16-bit capture/compare timer
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

`define TCC_ADDR_CMP_A_LO 4'h0
`define TCC_ADDR_CMP_A_HI 4'h1
`define TCC_ADDR_CMP_B_LO 4'h2
`define TCC_ADDR_CMP_B_HI 4'h3
`define TCC_ADDR_CAP_A_LO 4'h4
`define TCC_ADDR_CAP_A_HI 4'h5
`define TCC_ADDR_CAP_B_LO 4'h6
`define TCC_ADDR_CAP_B_HI 4'h7
`define TCC_ADDR_MODE 4'h8
`define TCC_ADDR_TOGGLE 4'h9
`define TCC_ADDR_RUN 4'ha
`define TCC_ADDR_PORT_DIR 4'hb
`define TCC_ADDR_PORT_FUNC 4'hc
`define TCC_ADDR_STATUS 4'hd

`define TCC_MODE_CLK_LSB 0
`define TCC_MODE_CAPM_LSB 2
`define TCC_MODE_CLR_BIT 4
`define TCC_MODE_SOFT_BIT 5
`define TCC_TOG_CMD_LSB 0
`define TCC_TOG_EN_LSB 2
`define TCC_RUN_CNT_BIT 4
`define TCC_RUN_PRE_BIT 5
`define TCC_PORT_BIT 3

`define TCC_CMP_RST 16'h0000
`define TCC_CAP_RST 16'h0000
`define TCC_TOG_EN_RST 4'h0
`define TCC_FF_RST 1'b0

`define TCC_FINE_LOG2 3
`define TCC_COARSE_LOG2 7

`endif

// file: common/tcc_pkg.sv
// types of the 16-bit capture/compare timer
`default_nettype none
package tcc_pkg;
	typedef enum logic [1:0] {TCC_CLK_EXT, TCC_CLK_FINE, TCC_CLK_COARSE, TCC_CLK_SPARE} tcc_clk_sel_t;
	typedef enum logic [1:0] {TCC_CAPM_OFF, TCC_CAPM_TWO_PIN, TCC_CAPM_PULSE, TCC_CAPM_FLIPFLOP} tcc_capm_t;
	typedef enum logic [1:0] {TCC_FF_CLR, TCC_FF_SET, TCC_FF_INV, TCC_FF_HOLD} tcc_ffcmd_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
		logic word;
	} tcc_bus_req_t;
	typedef struct packed {
		logic clr_en;
		tcc_capm_t capm;
		tcc_clk_sel_t clk_sel;
	} tcc_mode_t;
	typedef struct packed {
		logic cap_b;
		logic cap_a;
		logic match_b;
		logic match_a;
	} tcc_events_t;
endpackage
`default_nettype wire

// file: testbench/tcc_pin_src.sv
// pulse source model for the count and second capture pins
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_src (
	input wire logic clk_in,
	output logic cnt_pin_out,
	output logic sec_pin_out
);
	initial begin
		cnt_pin_out = 1'b0;
		sec_pin_out = 1'b0;
	end
	// seven clocks a level so the synced edge settles before the next change
	task automatic drive(input logic sec, input logic v);
		@(posedge clk_in);
		if (sec) sec_pin_out <= v;
		else cnt_pin_out <= v;
		repeat (6) @(posedge clk_in);
	endtask
	task automatic pulse(input logic sec, input int n);
		repeat (n) begin
			drive(sec, 1'b1);
			drive(sec, 1'b0);
		end
	endtask
endmodule // tcc_pin_src
`default_nettype wire

// file: testbench/timer16_capture_compare_tb_top.sv
// self-checking bench of the 16-bit capture/compare timer
`timescale 1ns/1ps
`include "tcc_params.svh"
`default_nettype none
module timer16_capture_compare_tb_top
	import tcc_pkg::*;
;
	logic clk_in, sys_rst_in, cnt_pin, sec_pin, port_level, pin_out, pin_oe, ia_irq, ib_irq, cap_irq;
	tcc_bus_req_t req;
	logic [15:0] rdata;
	int err_total, n_compared, n_ia, n_ib, n_cap, e_ia, e_ib, e_cap, seed, n, ca, cb, m_cnt, c1;
	logic m_ff, m_tog, m_clr;

	tcc_timer dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(req), .reg_rdata_out(rdata),
		.count_capture_input_in(cnt_pin), .second_capture_input_in(sec_pin), .port_level_in(port_level),
		.pulse_output_pin_out(pin_out), .pulse_output_pin_oe_out(pin_oe), .compare_a_interrupt_out(ia_irq),
		.compare_b_interrupt_out(ib_irq), .capture_input_interrupt_out(cap_irq));
	tcc_pin_src src (.clk_in(clk_in), .cnt_pin_out(cnt_pin), .sec_pin_out(sec_pin));

	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		n_ia <= n_ia + (ia_irq === 1'b1);
		n_ib <= n_ib + (ib_irq === 1'b1);
		n_cap <= n_cap + (cap_irq === 1'b1);
	end

	task automatic finish_test();
		if (err_total == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic w);
		@(posedge clk_in);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, word: w};
		@(posedge clk_in);
		req <= '0;
	endtask
	task automatic rd(input string what, input logic [3:0] a, input logic w, input logic [15:0] exp);
		@(posedge clk_in);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1, word: w};
		@(posedge clk_in);
		req <= '0;
		#1 chk(what, exp, rdata);
	endtask
	// reference counter, stepped once per count pin tick
	task automatic tick(input int k);
		repeat (k) begin
			if (m_cnt == ca) begin
				e_ia++;
				m_ff = m_ff ^ m_tog;
			end
			if (m_cnt == cb) begin
				e_ib++;
				m_ff = m_ff ^ m_tog;
			end
			m_cnt = (m_clr && m_cnt == cb) ? 0 : (m_cnt + 1) % 65536;
		end
	endtask
	task automatic cnt_pulses(input int k);
		src.pulse(1'b0, k);
		tick(k);
		e_cap += k;
	endtask
	task automatic restart();
		wr(`TCC_ADDR_RUN, 16'h0020, 1'b0);
		wr(`TCC_ADDR_RUN, 16'h0030, 1'b0);
		m_cnt = 0;
	endtask

	initial begin
		repeat (100000) @(posedge clk_in);
		err_total++;
		finish_test();
	end
	initial begin
		seed = 32'h46ef;
		sys_rst_in = 1'b1;
		req = '0;
		port_level = 1'($random(seed));
		{err_total, n_compared, n_ia, n_ib, n_cap, e_ia, e_ib, e_cap, ca, cb, m_cnt} = '0;
		{m_ff, m_tog, m_clr} = 3'b000;
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		#1 chk("pin_oe", 16'h0000, {15'h0, pin_oe});
		chk("pin_out", {15'h0, port_level}, {15'h0, pin_out});
		rd("mode", `TCC_ADDR_MODE, 1'b0, 16'h0020);
		rd("toggle", `TCC_ADDR_TOGGLE, 1'b0, 16'h0003);
		rd("unmapped", 4'hf, 1'b1, 16'h0000);
		wr(`TCC_ADDR_RUN, 16'h0030, 1'b0);
		n = 1 + $unsigned($random(seed)) % 8;
		cnt_pulses(n);
		src.pulse(1'b1, 1);
		wr(`TCC_ADDR_MODE, 16'h0000, 1'b0);
		rd("capture_a", `TCC_ADDR_CAP_A_LO, 1'b1, m_cnt[15:0]);
		rd("capture_a_lo", `TCC_ADDR_CAP_A_LO, 1'b0, {8'h00, m_cnt[7:0]});
		rd("capture_a_hi", `TCC_ADDR_CAP_A_HI, 1'b0, {8'h00, m_cnt[15:8]});
		rd("capture_b", `TCC_ADDR_CAP_B_LO, 1'b1, 16'h0000);
		restart();
		wr(`TCC_ADDR_MODE, 16'h0000, 1'b0);
		rd("capture_a", `TCC_ADDR_CAP_A_LO, 1'b1, 16'h0000);
		// pulse generation: duty from A, period from B
		cb = 3 + $unsigned($random(seed)) % 4;
		ca = 1 + $unsigned($random(seed)) % 2;
		wr(`TCC_ADDR_CMP_B_LO, cb[15:0], 1'b0);
		wr(`TCC_ADDR_CMP_B_HI, 16'h0000, 1'b0);
		wr(`TCC_ADDR_CMP_A_LO, ca[15:0], 1'b1);
		wr(`TCC_ADDR_MODE, 16'h0030, 1'b0);
		wr(`TCC_ADDR_TOGGLE, 16'h000f, 1'b0);
		wr(`TCC_ADDR_PORT_DIR, 16'h0008, 1'b0);
		wr(`TCC_ADDR_PORT_FUNC, 16'h0008, 1'b0);
		{m_clr, m_tog} = 2'b11;
		cnt_pulses(2 * cb + $unsigned($random(seed)) % 3);
		chk("irq_a", e_ia[15:0], n_ia[15:0]);
		chk("irq_b", e_ib[15:0], n_ib[15:0]);
		rd("status", `TCC_ADDR_STATUS, 1'b0, {15'h0, m_ff});
		chk("pin_out", {15'h0, m_ff}, {15'h0, pin_out});
		chk("pin_oe", 16'h0001, {15'h0, pin_oe});
		wr(`TCC_ADDR_MODE, 16'h0010, 1'b0);
		rd("capture_a", `TCC_ADDR_CAP_A_LO, 1'b1, m_cnt[15:0]);
		m_tog = 1'b0;
		for (int c = 0; c < 4; c++) begin
			wr(`TCC_ADDR_TOGGLE, 16'(c % 3), 1'b0);
			m_ff = (c % 3 == 2) ? ~m_ff : (c % 3 == 1);
			#1 chk("pin_out", {15'h0, m_ff}, {15'h0, pin_out});
		end
		// capture mode two pins, toggle on capture B
		wr(`TCC_ADDR_MODE, 16'h0024, 1'b0);
		wr(`TCC_ADDR_TOGGLE, 16'h0023, 1'b0);
		m_clr = 1'b0;
		restart();
		cnt_pulses(1 + $unsigned($random(seed)) % 5);
		chk("irq_cap", e_cap[15:0], n_cap[15:0]);
		src.pulse(1'b1, 1);
		m_ff = ~m_ff;
		rd("capture_b", `TCC_ADDR_CAP_B_LO, 1'b1, m_cnt[15:0]);
		chk("pin_out", {15'h0, m_ff}, {15'h0, pin_out});
		// pulse width mode: interrupt moves to falling edge
		wr(`TCC_ADDR_MODE, 16'h0028, 1'b0);
		src.drive(1'b0, 1'b1);
		tick(1);
		chk("irq_cap", e_cap[15:0], n_cap[15:0]);
		src.drive(1'b0, 1'b0);
		e_cap++;
		m_ff = ~m_ff;
		chk("irq_cap", e_cap[15:0], n_cap[15:0]);
		rd("capture_b", `TCC_ADDR_CAP_B_LO, 1'b1, m_cnt[15:0]);
		chk("pin_out", {15'h0, m_ff}, {15'h0, pin_out});
		// flip-flop edge capture
		wr(`TCC_ADDR_MODE, 16'h002c, 1'b0);
		wr(`TCC_ADDR_TOGGLE, 16'h0000, 1'b0);
		wr(`TCC_ADDR_TOGGLE, 16'h0001, 1'b0);
		c1 = m_cnt;
		cnt_pulses(2);
		wr(`TCC_ADDR_TOGGLE, 16'h0000, 1'b0);
		rd("capture_a", `TCC_ADDR_CAP_A_LO, 1'b1, c1[15:0]);
		rd("capture_b", `TCC_ADDR_CAP_B_LO, 1'b1, m_cnt[15:0]);
		chk("irq_cap", e_cap[15:0], n_cap[15:0]);
		// internal prescaler taps: counter steps once per tap period
		for (int s = 1; s < 3; s++) begin
			wr(`TCC_ADDR_RUN, 16'h0000, 1'b0);
			wr(`TCC_ADDR_MODE, 16'(16'h0020 | s), 1'b0);
			wr(`TCC_ADDR_RUN, 16'h0030, 1'b0);
			n = 20 + $unsigned($random(seed)) % 300;
			repeat (n) @(posedge clk_in);
			wr(`TCC_ADDR_MODE, 16'(s), 1'b0);
			c1 = (n + 1) >> ((s == 1) ? `TCC_FINE_LOG2 : `TCC_COARSE_LOG2);
			rd("capture_a_tap", `TCC_ADDR_CAP_A_LO, 1'b1, c1[15:0]);
		end
		finish_test();
	end
endmodule // timer16_capture_compare_tb_top
`default_nettype wire
